// ---- inc/cci_pkg.sv ----
// Purpose: constants shared by the CAN control and interrupt block
// Assumes: 32-bit AXI4-Lite register access, one word per register
// Notes: offsets are byte addresses
package cci_pkg;
  localparam int unsigned ADDR_W = 8;
  // register offsets
  localparam logic [ADDR_W-1:0] ADDR_MODULE_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_INTERRUPT_ENABLE_FLAG = 8'h04;
  // module control fields
  localparam int unsigned MODULE_ON_BIT = 15;
  localparam int unsigned HALT_IN_IDLE_BIT = 13;
  localparam int unsigned MODULE_ACTIVE_BIT = 11;
  localparam int unsigned COUNT_LSB = 0;
  localparam int unsigned COUNT_W = 5;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 5'h12;
  localparam int unsigned DATA_BITS_MAX = 18;
  // interrupt register layout: enables sit EN_SHIFT above their flags
  localparam int unsigned EN_SHIFT = 16;
  localparam logic [15:0] FLAG_IMPL = 16'hf80f;
  localparam int unsigned BAD_MESSAGE_BIT = 15;
  localparam int unsigned WAKEUP_BIT = 14;
  localparam int unsigned BUS_ERROR_BIT = 13;
  localparam int unsigned SYSTEM_ERROR_BIT = 12;
  localparam int unsigned RX_OVERFLOW_BIT = 11;
  localparam int unsigned MODE_CHANGE_BIT = 3;
  localparam int unsigned TIMESTAMP_BIT = 2;
  localparam int unsigned RX_BUFFER_BIT = 1;
  localparam int unsigned TX_BUFFER_BIT = 0;
  // reset values
  localparam logic [15:0] RST_ENABLES = 16'h0000;
  localparam logic [15:0] RST_FLAGS = 16'h0000;
  localparam logic [COUNT_W-1:0] RST_COUNT = 5'h00;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ---- verilog/cci_core.sv ----
// Purpose: control and interrupt section of a CAN controller, AXI4-Lite slave
// Assumes: event strobes and status levels come from logic on aclk
// Notes: two registers, module control and interrupt enable/flag
//
// Notes on behaviour
// (R01) halt_in_idle set stops the module in system idle; clear keeps it running.
// (R02) module_active reads 1 while active, 0 only once fully disabled.
// (R03) filter_data_bit_count selects how many data bits compare, 0 to 18.
// (R04) software must not write counts 19 to 31; they are invalid.
// (R05) switch-off waits for the current transaction; active stays set meanwhile.
// (R06) software polls module_active until 0 after requesting switch-off.
// (R07) enables in bits 31..27 gate the five error-class requests.
// (R08) enables in bits 19..16 gate mode, timestamp, rx and tx requests.
// (R09) event flags at 15..11 and 3..0, each sixteen below its enable.
// (R10) unimplemented bits read zero; enables and flags reset to zero.
// (R11) interrupt asserts whenever a flag and its enable are both set.
`timescale 1ns/1ps
`default_nettype none
module cci_core (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [cci_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [cci_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // system and protocol engine status
  input wire logic system_idle,
  input wire logic transaction_busy,
  // event strobes from the protocol engine
  input wire logic ev_bad_message,
  input wire logic ev_wakeup,
  input wire logic ev_bus_error,
  input wire logic ev_system_error,
  input wire logic ev_rx_overflow,
  input wire logic ev_mode_change,
  input wire logic ev_timestamp,
  input wire logic ev_rx_buffer,
  input wire logic ev_tx_buffer,
  // control towards the protocol engine
  output logic module_run,
  output logic module_active,
  output logic [cci_pkg::DATA_BITS_MAX-1:0] data_compare_mask,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic aw_held_q, aw_held_d, w_held_q, w_held_d;
  logic [cci_pkg::ADDR_W-1:0] waddr_q, waddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [1:0] rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic on_q, on_d, halt_q, halt_d;
  logic active_q, active_d, run_q, run_d, irq_q, irq_d;
  logic [cci_pkg::COUNT_W-1:0] count_q, count_d;
  logic [15:0] en_q, en_d, flag_q, flag_d;
  logic [cci_pkg::DATA_BITS_MAX-1:0] mask_q, mask_d;
  logic [15:0] events;
  logic do_write;
  logic [31:0] ctrl_word, int_word;

  assign events = {ev_bad_message, ev_wakeup, ev_bus_error, ev_system_error,
                   ev_rx_overflow, 7'h00, ev_mode_change, ev_timestamp,
                   ev_rx_buffer, ev_tx_buffer};

  // unimplemented positions are never stored, so they read zero
  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[cci_pkg::MODULE_ON_BIT] = on_q;
    ctrl_word[cci_pkg::HALT_IN_IDLE_BIT] = halt_q;
    ctrl_word[cci_pkg::MODULE_ACTIVE_BIT] = active_q; // R02
    ctrl_word[cci_pkg::COUNT_LSB +: cci_pkg::COUNT_W] = count_q;
    int_word = {en_q & cci_pkg::FLAG_IMPL, flag_q & cci_pkg::FLAG_IMPL}; // R10
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus: address and data are caught in either order, then answered
  assign do_write = aw_held_q && w_held_q && !bvalid_q;

  always_comb begin
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (s_axi_awvalid && !aw_held_q) begin
      aw_held_d = 1'b1;
      waddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held_q) begin
      w_held_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (do_write) begin
      bvalid_d = 1'b1;
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      if (waddr_q == cci_pkg::ADDR_MODULE_CONTROL ||
          waddr_q == cci_pkg::ADDR_INTERRUPT_ENABLE_FLAG) begin
        bresp_d = cci_pkg::RESP_OKAY;
      end else begin
        bresp_d = cci_pkg::RESP_SLVERR;
      end
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d = cci_pkg::RESP_OKAY;
      if (s_axi_araddr == cci_pkg::ADDR_MODULE_CONTROL) begin
        rdata_d = ctrl_word;
      end else if (s_axi_araddr == cci_pkg::ADDR_INTERRUPT_ENABLE_FLAG) begin
        rdata_d = int_word;
      end else begin
        rdata_d = 32'h0000_0000;
        rresp_d = cci_pkg::RESP_SLVERR;
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      waddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= cci_pkg::RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= cci_pkg::RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready = !w_held_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // registers and block behaviour
  always_comb begin
    on_d = on_q;
    halt_d = halt_q;
    count_d = count_q;
    en_d = en_q;
    if (do_write && waddr_q == cci_pkg::ADDR_MODULE_CONTROL) begin
      if (wstrb_q[1]) begin
        on_d = wdata_q[cci_pkg::MODULE_ON_BIT];
        halt_d = wdata_q[cci_pkg::HALT_IN_IDLE_BIT];
      end
      if (wstrb_q[0]) begin
        count_d = wdata_q[cci_pkg::COUNT_LSB +: cci_pkg::COUNT_W];
      end
    end
    if (do_write && waddr_q == cci_pkg::ADDR_INTERRUPT_ENABLE_FLAG) begin
      if (wstrb_q[3]) begin
        en_d[15:8] = wdata_q[31:24] & cci_pkg::FLAG_IMPL[15:8]; // R07
      end
      if (wstrb_q[2]) begin
        en_d[7:0] = wdata_q[23:16] & cci_pkg::FLAG_IMPL[7:0]; // R08
      end
    end
    // write one clears a flag; a same-cycle event wins over the clear
    flag_d = flag_q;
    if (do_write && waddr_q == cci_pkg::ADDR_INTERRUPT_ENABLE_FLAG) begin
      flag_d = flag_q & ~({{8{wstrb_q[1]}}, {8{wstrb_q[0]}}} & wdata_q[15:0]);
    end
    flag_d = (flag_d | events) & cci_pkg::FLAG_IMPL; // R09
    // a switch-off request holds active until the transaction ends
    active_d = on_q || transaction_busy; // R02 R05
    run_d = on_q && !(halt_q && system_idle); // R01
    irq_d = |(flag_q & en_q); // R11 R07 R08
  end

  // counts above the legal top compare the full eighteen bits
  genvar gi;
  generate
    for (gi = 0; gi < cci_pkg::DATA_BITS_MAX; gi++) begin : g_mask
      assign mask_d[gi] = (count_q > cci_pkg::COUNT_MAX) ||
                          (count_q > cci_pkg::COUNT_W'(gi)); // R03
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      on_q <= 1'b0;
      halt_q <= 1'b0;
      count_q <= cci_pkg::RST_COUNT;
      en_q <= cci_pkg::RST_ENABLES; // R10
      flag_q <= cci_pkg::RST_FLAGS; // R10
      active_q <= 1'b0;
      run_q <= 1'b0;
      irq_q <= 1'b0;
      mask_q <= '0;
    end else begin
      on_q <= on_d;
      halt_q <= halt_d;
      count_q <= count_d;
      en_q <= en_d;
      flag_q <= flag_d;
      active_q <= active_d;
      run_q <= run_d;
      irq_q <= irq_d;
      mask_q <= mask_d;
    end
  end

  assign module_run = run_q;
  assign module_active = active_q;
  assign data_compare_mask = mask_q;
  assign irq = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_halt_idle;
    on_q && halt_q && system_idle |=> !module_run;
  endproperty
  a_halt_idle: assert property (p_halt_idle) else $error("module runs in idle"); // R01

  property p_run_idle;
    on_q && !halt_q |=> module_run;
  endproperty
  a_run_idle: assert property (p_run_idle) else $error("module stopped"); // R01

  property p_off_done;
    !on_q && !transaction_busy |=> !module_active;
  endproperty
  a_off_done: assert property (p_off_done) else $error("active after stop"); // R02

  property p_off_wait;
    $fell(on_q) && transaction_busy |-> module_active ##1 module_active;
  endproperty
  a_off_wait: assert property (p_off_wait) else $error("active dropped early"); // R05

  property p_mask;
    1'b1 |=> $countones(data_compare_mask) ==
      (($past(count_q) > cci_pkg::COUNT_MAX) ? 18 : int'($past(count_q)));
  endproperty
  a_mask: assert property (p_mask) else $error("compare mask width wrong"); // R03

  // every event strobe lands in its flag on the next edge, even against a clear
  property p_flag_set;
    |events |=> (flag_q & $past(events)) == $past(events);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set"); // R09

  property p_irq_on;
    (flag_q & en_q) != 16'h0000 |=> irq;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq missing"); // R11

  property p_irq_gate;
    (flag_q & en_q) == 16'h0000 |=> !irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq not gated"); // R08

  // bit 4 is a count bit in the control word, so only the shared gaps are checked
  property p_reserved;
    rvalid_q |-> (rdata_q & 32'h07f0_07e0) == 32'h0000_0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set"); // R10

  property p_en_write;
    do_write && waddr_q == cci_pkg::ADDR_INTERRUPT_ENABLE_FLAG && wstrb_q[3]
      |=> en_q[15:11] == $past(wdata_q[31:27]);
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable write lost"); // R07

endmodule
`default_nettype wire

// ---- sim/cci_engine_model.sv ----
// Purpose: protocol engine stand-in feeding events and status to the block
// Assumes: bench commands change right after a rising edge of aclk
// Notes: each request bit is registered into its strobe, one cycle later and for as many cycles as it is held
`timescale 1ns/1ps
`default_nettype none
module cci_engine_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bench commands
  input wire logic [8:0] fire,
  input wire logic busy_req,
  input wire logic idle_req,
  // towards the block
  output logic system_idle,
  output logic transaction_busy,
  output logic ev_bad_message,
  output logic ev_wakeup,
  output logic ev_bus_error,
  output logic ev_system_error,
  output logic ev_rx_overflow,
  output logic ev_mode_change,
  output logic ev_timestamp,
  output logic ev_rx_buffer,
  output logic ev_tx_buffer
);
  logic [8:0] ev_q;
  // registered so strobes never glitch within the bench's edge
  always_ff @(posedge aclk) begin
    ev_q <= aresetn ? fire : 9'h000;
    system_idle <= idle_req;
    transaction_busy <= busy_req;
  end
  assign {ev_bad_message, ev_wakeup, ev_bus_error, ev_system_error, ev_rx_overflow} = ev_q[8:4];
  assign {ev_mode_change, ev_timestamp, ev_rx_buffer, ev_tx_buffer} = ev_q[3:0];
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
// Purpose: self-checking bench for the control and interrupt block
// Assumes: axi4-lite master tasks, engine model on the far side
// Notes: random event and enable patterns from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, rd, fl, en;
  logic system_idle, transaction_busy, module_run, module_active, irq;
  logic ev_bad_message, ev_wakeup, ev_bus_error, ev_system_error, ev_rx_overflow;
  logic ev_mode_change, ev_timestamp, ev_rx_buffer, ev_tx_buffer;
  logic [17:0] data_compare_mask;
  logic [8:0] fire = 9'h000;
  logic busy_req = 1'b0, idle_req = 1'b0;
  logic [7:0] a_ctl = cci_pkg::ADDR_MODULE_CONTROL, a_int = cci_pkg::ADDR_INTERRUPT_ENABLE_FLAG;
  int failures = 0, num_checks = 0, seed = 32'h7d16dc72, c, n, b;
  int fb[9] = '{15, 14, 13, 12, 11, 3, 2, 1, 0};
  always #5 aclk = ~aclk;
  cci_engine_model eng (.aclk, .aresetn, .fire, .busy_req, .idle_req, .system_idle,
    .transaction_busy, .ev_bad_message, .ev_wakeup, .ev_bus_error, .ev_system_error,
    .ev_rx_overflow, .ev_mode_change, .ev_timestamp, .ev_rx_buffer, .ev_tx_buffer);
  cci_core DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .system_idle, .transaction_busy, .ev_bad_message, .ev_wakeup, .ev_bus_error,
    .ev_system_error, .ev_rx_overflow, .ev_mode_change, .ev_timestamp, .ev_rx_buffer,
    .ev_tx_buffer, .module_run, .module_active, .data_compare_mask, .irq);
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [17:0] exp_mask(input int k);
    return (18'h0_0001 << k) - 18'h0_0001;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge aclk);
    #1;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic complete_run;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (50000) @(posedge aclk);
    failures++;
    complete_run;
  end
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    tick(1);
    chk("active_rst", module_active, 0);
    axi_rd(a_ctl);
    chk("ctrl_rst", rd, 0);
    axi_rd(a_int);
    chk("int_rst", rd, 0);
    axi_wr(a_int, 32'hffff_ffff, 4'h8);
    axi_rd(a_int);
    chk("int_lane3", rd, 32'hf800_0000);
    axi_wr(a_int, 32'hffff_ffff, 4'hf);
    axi_rd(a_int);
    chk("int_all", rd, 32'hf80f_0000);
    axi_wr(a_int, 32'h0000_0000, 4'hf);
    axi_wr(a_ctl, 32'hffff_ffff, 4'hf);
    chk("wr_okay", rs, cci_pkg::RESP_OKAY);
    axi_rd(a_ctl);
    chk("ctrl_all", rd, 32'h0000_a81f);
    chk("mask_invalid", data_compare_mask, 18'h3_ffff);
    for (n = 0; n < 27; n++) begin
      c = (n < 19) ? n : {$random(seed)} % 19;
      axi_wr(a_ctl, 32'h0000_8000 | c, 4'hf);
      tick(2);
      chk("compare_mask", data_compare_mask, exp_mask(c));
    end
    axi_wr(a_ctl, 32'h0000_a000, 4'hf);
    @(posedge aclk) idle_req <= 1'b1;
    tick(4);
    chk("run_halted", module_run, 0);
    @(posedge aclk) idle_req <= 1'b0;
    tick(4);
    chk("run_awake", module_run, 1);
    axi_wr(a_ctl, 32'h0000_8000, 4'hf);
    @(posedge aclk) idle_req <= 1'b1;
    tick(4);
    chk("run_idle", module_run, 1);
    @(posedge aclk) busy_req <= 1'b1;
    axi_wr(a_ctl, 32'h0000_0000, 4'hf);
    tick(4);
    chk("active_busy", module_active, 1);
    axi_rd(a_ctl);
    chk("busy_bit", rd, 32'h0000_0800);
    @(posedge aclk) busy_req <= 1'b0;
    for (n = 0; n < 20 && rd[11] !== 1'b0; n++) axi_rd(a_ctl);
    chk("off_bit", rd, 0);
    chk("active_off", module_active, 0);
    for (n = 0; n < 9; n++) begin
      b = fb[n];
      @(posedge aclk) fire <= 9'h100 >> n;
      @(posedge aclk) fire <= 9'h000;
      tick(3);
      axi_rd(a_int);
      chk("flag_set", rd, 32'h1 << b);
      chk("irq_masked", irq, 0);
      axi_wr(a_int, 32'h1 << (b + 16), 4'hf);
      tick(2);
      chk("irq_on", irq, 1);
      axi_wr(a_int, (32'h1 << (b + 16)) | (32'h1 << b), 4'hf);
      tick(2);
      chk("irq_clr", irq, 0);
      axi_rd(a_int);
      chk("flag_clr", rd, 32'h1 << (b + 16));
      axi_wr(a_int, 32'h0000_0000, 4'hf);
    end
    repeat (8) begin
      c = $random(seed);
      en = $random(seed) & 32'hf80f_0000;
      fl = 32'h0;
      for (n = 0; n < 9; n++) fl[fb[n]] = c[8 - n];
      @(posedge aclk) fire <= c[8:0];
      @(posedge aclk) fire <= 9'h000;
      axi_wr(a_int, en, 4'hf);
      tick(2);
      chk("irq_rand", irq, |(en[31:16] & fl[15:0]));
      axi_rd(a_int);
      chk("int_rand", rd, en | fl);
      axi_wr(a_int, 32'h0000_ffff, 4'hf);
    end
    // event strobe lands in the very cycle of the write-one clear: set must win
    fork
      axi_wr(a_int, 32'h0000_ffff, 4'hf);
      begin
        @(posedge aclk) fire <= 9'h100;
        @(posedge aclk) fire <= 9'h000;
      end
    join
    axi_rd(a_int);
    chk("flag_set_wins", rd, 32'h0000_8000);
    axi_wr(8'h08, 32'hffff_ffff, 4'hf);
    chk("wr_unmapped", rs, cci_pkg::RESP_SLVERR);
    axi_rd(8'h08);
    chk("rd_unmapped", rd, 0);
    chk("rd_slverr", rs, cci_pkg::RESP_SLVERR);
    complete_run;
  end
endmodule
`default_nettype wire
